// file: verilog/supervisor_pkg.sv
// Overview of operation
// - Watchdog counts slow clocks; four selectable timeouts.
// - Watchdog timeout resets the whole device.
// - Watchdog-clear instruction restarts count from zero.
// - First watchdog period after wake may be short.
// - Six request lines, each with enable bit.
// - Hardware sets flags; software write clears them.
// - Flags set regardless of their enable bit.
// - Edge select picks rising, falling or both.
// - Global enable gates all lines; set/clear instructions.
// - Take: push PC, sp+2, clear global, vector.
// - Return: pop PC, sp-2, set global enable.
// - Context save/restore pushes and pops accumulator, flags.
// - Power-down stops fast and slow oscillators only.
// - Power-save gates system clock and program memory.
// - Timers stop in power-save if sysclk or oscillator off.
// - Pin toggle wakes when direction and input-enable set.
// - Non-sysclk timer match wakes from power-save.
// - Eight-bit timers on nano oscillator wake, oscillator enabled.
// - Comparator wakes only with enable and wake enable.
// - Resume after 16 slow clocks, 8 when fast.
// - Power-down wakes only by pin or nano eight-bit timers.
package supervisor_pkg;
	localparam logic [11:0] ADDR_INT_ENABLE = 12'h000;
	localparam logic [11:0] ADDR_INT_FLAGS = 12'h004;
	localparam logic [11:0] ADDR_EDGE_SELECT = 12'h008;
	localparam logic [11:0] ADDR_MISC_CTRL = 12'h00c;
	localparam logic [11:0] ADDR_STACK_PTR = 12'h010;
	localparam logic [11:0] ADDR_AUX_CTRL_TWO = 12'h014;
	localparam logic [11:0] ADDR_TIMER_SRC = 12'h018;
	localparam logic [11:0] ADDR_PIN_CFG = 12'h01c;
	localparam logic [11:0] ADDR_STATUS = 12'h020;

	localparam int NUM_LINES = 6;
	localparam int LINE_EXT_PIN = 0;
	localparam int LINE_T16 = 1;
	localparam int LINE_T2 = 2;
	localparam int LINE_T3 = 3;
	localparam int LINE_CMP = 4;
	localparam int LINE_LPWM = 5;

	localparam logic [1:0] EDGE_BOTH = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;

	localparam logic [1:0] SRC_SYSCLK = 2'h0;
	localparam logic [1:0] SRC_FAST = 2'h1;
	localparam logic [1:0] SRC_SLOW = 2'h2;
	localparam logic [1:0] SRC_NANO = 2'h3;

	localparam int MISC_WDT_SEL_LO = 0;
	localparam int MISC_FAST_WAKE = 5;
	localparam int MISC_WDT_EN = 8;
	localparam int MISC_FAST_OSC_EN = 9;
	localparam int MISC_SLOW_OSC_EN = 10;
	localparam int AUX_NANO_EN = 0;
	localparam int AUX_CMP_EN = 1;
	localparam int AUX_CMP_WAKE_EN = 2;

	localparam logic [1:0] WDT_SEL_RESET = 2'h0;
	localparam logic [7:0] SP_RESET = 8'h00;
	localparam logic [15:0] INT_VECTOR = 16'h0010;
	localparam logic [7:0] STACK_STEP = 8'h02;

	localparam int WDT_W = 18;
	localparam int WDT_TIMEOUT_0 = 8192;
	localparam int WDT_TIMEOUT_1 = 16384;
	localparam int WDT_TIMEOUT_2 = 65536;
	localparam int WDT_TIMEOUT_3 = 262144;
	localparam logic [4:0] WAKE_SLOW_CLKS_NORMAL = 5'h10;
	localparam logic [4:0] WAKE_SLOW_CLKS_FAST = 5'h08;

	typedef enum logic [3:0] {
		MODE_ON = 4'b0001,
		MODE_SAVE = 4'b0010,
		MODE_DOWN = 4'b0100,
		MODE_WAKE = 4'b1000
	} power_mode_t;

	typedef enum logic [3:0] {
		STK_IDLE = 4'b0001,
		STK_PUSH_HI = 4'b0010,
		STK_POP_A = 4'b0100,
		STK_POP_B = 4'b1000
	} stack_state_t;
endpackage

// file: verilog/interrupt_sleep_watchdog.sv
`default_nettype none
module interrupt_sleep_watchdog
	import supervisor_pkg::*;
#(
	parameter int WDT_T0 = WDT_TIMEOUT_0,
	parameter int WDT_T1 = WDT_TIMEOUT_1,
	parameter int WDT_T2 = WDT_TIMEOUT_2,
	parameter int WDT_T3 = WDT_TIMEOUT_3
) (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic slow_rc_osc_in,
	input wire logic [5:0] pins_in,
	input wire logic comparator_unit_in,
	input wire logic sixteen_bit_timer_bit_in,
	input wire logic [1:0] eight_bit_timer_irq_in,
	input wire logic led_pwm_generator_irq_in,
	input wire logic sixteen_bit_timer_match_in,
	input wire logic [1:0] eight_bit_timer_match_in,
	input wire logic instr_boundary_in,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] working_register_in,
	input wire logic [7:0] flag_register_in,
	input wire logic wdt_clear_in,
	input wire logic global_enable_in,
	input wire logic global_disable_in,
	input wire logic return_irq_in,
	input wire logic context_save_in,
	input wire logic context_restore_in,
	input wire logic power_save_in,
	input wire logic power_down_in,
	input wire logic [7:0] mem_rdata_in,
	output logic [7:0] mem_addr_out,
	output logic [7:0] mem_wdata_out,
	output logic mem_we_out,
	output logic mem_re_out,
	output logic core_stall_out,
	output logic pc_load_out,
	output logic [15:0] pc_value_out,
	output logic context_load_out,
	output logic [7:0] working_register_out,
	output logic [7:0] flag_register_out,
	output logic chip_reset_out,
	output logic sys_clk_en_out,
	output logic program_mem_on_out,
	output logic fast_rc_osc_en_out,
	output logic slow_rc_osc_en_out,
	output logic nano_rc_osc_en_out,
	output logic [3:0] timer_run_out
);
	typedef struct packed {
		logic [2:0] osc_s1;
		logic [2:0] osc_s2;
		logic [5:0] pin_s1;
		logic [5:0] pin_s2;
		logic slow_prev;
		logic [5:0] pin_prev;
		logic [5:0] src_prev;
		logic [5:0] int_enable;
		logic [5:0] flags;
		logic [11:0] edge_sel;
		logic [10:0] misc;
		logic [2:0] aux2;
		logic [7:0] timer_src;
		logic [5:0] pin_dir;
		logic [5:0] pin_die;
		logic [7:0] sp;
		logic gie;
		power_mode_t mode;
		logic [4:0] wake_cnt;
		logic [WDT_W-1:0] wdt_cnt;
		logic wdt_rst;
		stack_state_t stk;
		logic pop_hi;
		logic stk_is_pc;
		logic [7:0] lo_byte;
		logic [7:0] mem_addr;
		logic [7:0] mem_wdata;
		logic mem_we;
		logic mem_re;
		logic pc_load;
		logic [15:0] pc_value;
		logic ctx_load;
		logic [7:0] acc_out;
		logic [7:0] flg_out;
		logic [31:0] prdata;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	localparam logic [WDT_W-1:0] WDT_LIM0 = WDT_W'(WDT_T0 - 1);
	localparam logic [WDT_W-1:0] WDT_LIM1 = WDT_W'(WDT_T1 - 1);
	localparam logic [WDT_W-1:0] WDT_LIM2 = WDT_W'(WDT_T2 - 1);
	localparam logic [WDT_W-1:0] WDT_LIM3 = WDT_W'(WDT_T3 - 1);

	function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
		logic rise;
		logic fall;
		rise = cur & ~prev;
		fall = prev & ~cur;
		case (sel)
			EDGE_RISE: edge_hit = rise;
			EDGE_FALL: edge_hit = fall;
			default: edge_hit = rise | fall;
		endcase
	endfunction

	function automatic logic osc_running(input logic [1:0] src, input logic fast_on,
		input logic slow_on, input logic nano_on);
		case (src)
			SRC_FAST: osc_running = fast_on;
			SRC_SLOW: osc_running = slow_on;
			SRC_NANO: osc_running = nano_on;
			default: osc_running = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		lane_merge = strb[0] ? wd[7:0] : old;
	endfunction

	logic apb_setup;
	logic apb_write;
	logic addr_ok;
	logic slow_tick;
	logic [5:0] src_now;
	logic [5:0] edge_ev;
	logic [5:0] clr_mask;
	logic [WDT_W-1:0] wdt_limit;
	logic fast_on;
	logic slow_on;
	logic nano_on;
	logic [3:0] run;
	logic [5:0] pin_toggle;
	logic wake_pin;
	logic wake_t16;
	logic [1:0] wake_t8;
	logic wake_cmp;
	logic wake_ev;
	logic take_irq;
	logic [15:0] wr_hi;
	logic [15:0] wr_lo;

	assign pready_out = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~addr_ok;
	assign apb_setup = psel_in & ~penable_in;
	assign apb_write = psel_in & penable_in & pwrite_in;

	always_comb begin
		case (paddr_in)
			ADDR_INT_ENABLE, ADDR_INT_FLAGS, ADDR_EDGE_SELECT, ADDR_MISC_CTRL,
			ADDR_STACK_PTR, ADDR_AUX_CTRL_TWO, ADDR_TIMER_SRC, ADDR_PIN_CFG,
			ADDR_STATUS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	always_comb begin
		case (s_r.misc[MISC_WDT_SEL_LO +: 2])
			2'h1: wdt_limit = WDT_LIM1;
			2'h2: wdt_limit = WDT_LIM2;
			2'h3: wdt_limit = WDT_LIM3;
			default: wdt_limit = WDT_LIM0;
		endcase
	end

	always_comb begin
		slow_tick = s_r.osc_s2[0] & ~s_r.slow_prev;
		src_now = {led_pwm_generator_irq_in, s_r.osc_s2[1], eight_bit_timer_irq_in,
			sixteen_bit_timer_bit_in, s_r.pin_s2[0]};
		for (int i = 0; i < NUM_LINES; i++) begin
			edge_ev[i] = edge_hit(s_r.src_prev[i], src_now[i], s_r.edge_sel[2*i +: 2]);
		end
		// Power-down stops the fast and slow oscillators; the nano one is left as it is.
		fast_on = s_r.misc[MISC_FAST_OSC_EN] & (s_r.mode != MODE_DOWN);
		slow_on = s_r.misc[MISC_SLOW_OSC_EN] & (s_r.mode != MODE_DOWN);
		nano_on = s_r.aux2[AUX_NANO_EN];
		for (int t = 0; t < 4; t++) begin
			run[t] = (s_r.mode == MODE_ON) |
				osc_running(s_r.timer_src[2*t +: 2], fast_on, slow_on, nano_on);
		end
		pin_toggle = s_r.pin_s2 ^ s_r.pin_prev;
		wake_pin = |(pin_toggle & s_r.pin_dir & s_r.pin_die);
		wake_t16 = sixteen_bit_timer_match_in & run[0] &
			(s_r.timer_src[1:0] != SRC_SYSCLK);
		for (int k = 0; k < 2; k++) begin
			wake_t8[k] = eight_bit_timer_match_in[k] & run[k+1] &
				(s_r.timer_src[2*(k+1) +: 2] != SRC_SYSCLK);
		end
		wake_cmp = s_r.aux2[AUX_CMP_EN] & s_r.aux2[AUX_CMP_WAKE_EN] &
			(s_r.osc_s2[1] ^ s_r.src_prev[LINE_CMP]);
		if (s_r.mode == MODE_DOWN) begin
			// Only nano-clocked timers can still run here, so any t8 wake is from one.
			wake_ev = wake_pin | (|(wake_t8 & {2{nano_on}}));
		end else begin
			wake_ev = wake_pin | wake_t16 | (|wake_t8) | wake_cmp;
		end
		take_irq = instr_boundary_in & s_r.gie & (s_r.mode == MODE_ON) &
			(s_r.stk == STK_IDLE) & (|(s_r.flags & s_r.int_enable));
		clr_mask = 6'h3f;
		if (apb_write && paddr_in == ADDR_INT_FLAGS && pstrb_in[0]) begin
			clr_mask = pwdata_in[5:0];
		end
		wr_lo = pwdata_in[15:0];
		wr_hi = pwdata_in[31:16];
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.osc_s1 = {1'b0, comparator_unit_in, slow_rc_osc_in};
		s_nxt.osc_s2 = s_r.osc_s1;
		s_nxt.pin_s1 = pins_in;
		s_nxt.pin_s2 = s_r.pin_s1;
		s_nxt.slow_prev = s_r.osc_s2[0];
		s_nxt.pin_prev = s_r.pin_s2;
		s_nxt.src_prev = src_now;
		s_nxt.mem_we = 1'b0;
		s_nxt.mem_re = 1'b0;
		s_nxt.pc_load = 1'b0;
		s_nxt.ctx_load = 1'b0;
		s_nxt.wdt_rst = 1'b0;

		// Set wins over clear, so an edge in the clearing cycle is kept.
		s_nxt.flags = (s_r.flags & clr_mask) | edge_ev;

		if (apb_setup) begin
			case (paddr_in)
				ADDR_INT_ENABLE: s_nxt.prdata = {26'h0, s_r.int_enable};
				ADDR_INT_FLAGS: s_nxt.prdata = {26'h0, s_r.flags};
				ADDR_EDGE_SELECT: s_nxt.prdata = {20'h0, s_r.edge_sel};
				ADDR_MISC_CTRL: s_nxt.prdata = {21'h0, s_r.misc};
				ADDR_STACK_PTR: s_nxt.prdata = {24'h0, s_r.sp};
				ADDR_AUX_CTRL_TWO: s_nxt.prdata = {29'h0, s_r.aux2};
				ADDR_TIMER_SRC: s_nxt.prdata = {24'h0, s_r.timer_src};
				ADDR_PIN_CFG: s_nxt.prdata = {18'h0, s_r.pin_die, 2'h0, s_r.pin_dir};
				ADDR_STATUS: s_nxt.prdata = {s_r.wdt_cnt, 5'h0, s_r.gie,
					s_r.mode, s_r.stk};
				default: s_nxt.prdata = 32'h0;
			endcase
		end

		if (apb_write) begin
			case (paddr_in)
				ADDR_INT_ENABLE: begin
					if (pstrb_in[0]) s_nxt.int_enable = wr_lo[5:0];
				end
				ADDR_EDGE_SELECT: begin
					if (pstrb_in[0]) s_nxt.edge_sel[7:0] = wr_lo[7:0];
					if (pstrb_in[1]) s_nxt.edge_sel[11:8] = wr_lo[11:8];
				end
				ADDR_MISC_CTRL: begin
					if (pstrb_in[0]) s_nxt.misc[7:0] = wr_lo[7:0];
					if (pstrb_in[1]) s_nxt.misc[10:8] = wr_lo[10:8];
				end
				ADDR_STACK_PTR: s_nxt.sp = lane_merge(s_r.sp, pwdata_in, pstrb_in);
				ADDR_AUX_CTRL_TWO: begin
					if (pstrb_in[0]) s_nxt.aux2 = wr_lo[2:0];
				end
				ADDR_TIMER_SRC: s_nxt.timer_src = lane_merge(s_r.timer_src, pwdata_in, pstrb_in);
				ADDR_PIN_CFG: begin
					if (pstrb_in[0]) s_nxt.pin_dir = wr_lo[5:0];
					if (pstrb_in[1]) s_nxt.pin_die = wr_lo[13:8];
				end
				default: s_nxt.prdata = s_nxt.prdata;
			endcase
			if (paddr_in == ADDR_STATUS && pstrb_in[3]) begin
				s_nxt.prdata = {wr_hi, s_nxt.prdata[15:0]} & 32'h0;
			end
		end

		if (global_enable_in) begin
			s_nxt.gie = 1'b1;
		end
		if (global_disable_in) begin
			s_nxt.gie = 1'b0;
		end

		case (s_r.stk)
			STK_IDLE: begin
				if (take_irq) begin
					s_nxt.mem_addr = s_r.sp;
					s_nxt.mem_wdata = pc_in[7:0];
					s_nxt.mem_we = 1'b1;
					s_nxt.lo_byte = pc_in[15:8];
					s_nxt.stk_is_pc = 1'b1;
					s_nxt.gie = 1'b0;
					s_nxt.stk = STK_PUSH_HI;
				end else if (context_save_in) begin
					s_nxt.mem_addr = s_r.sp;
					s_nxt.mem_wdata = working_register_in;
					s_nxt.mem_we = 1'b1;
					s_nxt.lo_byte = flag_register_in;
					s_nxt.stk_is_pc = 1'b0;
					s_nxt.stk = STK_PUSH_HI;
				end else if (return_irq_in || context_restore_in) begin
					s_nxt.mem_addr = s_r.sp - STACK_STEP;
					s_nxt.mem_re = 1'b1;
					s_nxt.stk_is_pc = return_irq_in;
					s_nxt.stk = STK_POP_A;
				end
			end
			STK_PUSH_HI: begin
				s_nxt.mem_addr = s_r.sp + 8'h01;
				s_nxt.mem_wdata = s_r.lo_byte;
				s_nxt.mem_we = 1'b1;
				s_nxt.sp = s_r.sp + STACK_STEP;
				s_nxt.pc_load = s_r.stk_is_pc;
				s_nxt.pc_value = INT_VECTOR;
				s_nxt.stk = STK_IDLE;
			end
			STK_POP_A: begin
				s_nxt.mem_addr = s_r.sp - 8'h01;
				s_nxt.mem_re = 1'b1;
				s_nxt.stk = STK_POP_B;
			end
			STK_POP_B: begin
				// Read data trails its address by one cycle: low byte first, high byte next.
				if (!s_r.pop_hi) begin
					s_nxt.lo_byte = mem_rdata_in;
					s_nxt.pop_hi = 1'b1;
				end else begin
					s_nxt.pop_hi = 1'b0;
					s_nxt.stk = STK_IDLE;
					s_nxt.sp = s_r.sp - STACK_STEP;
					if (s_r.stk_is_pc) begin
						s_nxt.pc_load = 1'b1;
						s_nxt.pc_value = {mem_rdata_in, s_r.lo_byte};
						s_nxt.gie = 1'b1;
					end else begin
						s_nxt.ctx_load = 1'b1;
						s_nxt.acc_out = s_r.lo_byte;
						s_nxt.flg_out = mem_rdata_in;
					end
				end
			end
			default: s_nxt.stk = STK_IDLE;
		endcase

		case (s_r.mode)
			MODE_ON: begin
				if (power_down_in && s_r.stk == STK_IDLE) begin
					s_nxt.mode = MODE_DOWN;
				end else if (power_save_in && s_r.stk == STK_IDLE) begin
					s_nxt.mode = MODE_SAVE;
				end
			end
			MODE_SAVE, MODE_DOWN: begin
				if (wake_ev) begin
					s_nxt.mode = MODE_WAKE;
					s_nxt.wake_cnt = s_r.misc[MISC_FAST_WAKE] ? WAKE_SLOW_CLKS_FAST :
						WAKE_SLOW_CLKS_NORMAL;
				end
			end
			MODE_WAKE: begin
				if (slow_tick) begin
					s_nxt.wake_cnt = s_r.wake_cnt - 5'h01;
					if (s_r.wake_cnt == 5'h01) begin
						s_nxt.mode = MODE_ON;
					end
				end
			end
			default: s_nxt.mode = MODE_ON;
		endcase

		// The count is kept across sleep, so the first period after a wake can be short.
		if (wdt_clear_in) begin
			s_nxt.wdt_cnt = '0;
		end else if (s_r.misc[MISC_WDT_EN] && slow_tick && s_r.mode != MODE_DOWN) begin
			s_nxt.wdt_cnt = s_r.wdt_cnt + 1'b1;
			if (s_r.wdt_cnt == wdt_limit) begin
				s_nxt = '0;
				s_nxt.mode = MODE_ON;
				s_nxt.stk = STK_IDLE;
				s_nxt.misc[MISC_SLOW_OSC_EN] = 1'b1;
				s_nxt.misc[MISC_FAST_OSC_EN] = 1'b1;
				s_nxt.misc[MISC_WDT_EN] = 1'b1;
				s_nxt.pc_value = 16'h0000;
				s_nxt.wdt_rst = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			s_r <= '0;
			s_r.mode <= MODE_ON;
			s_r.stk <= STK_IDLE;
			s_r.sp <= SP_RESET;
			s_r.misc <= {1'b1, 1'b1, 1'b1, 6'h0, WDT_SEL_RESET};
		end else if (ce_in) begin
			s_r <= s_nxt;
		end
	end

	assign prdata_out = s_r.prdata;
	assign mem_addr_out = s_r.mem_addr;
	assign mem_wdata_out = s_r.mem_wdata;
	assign mem_we_out = s_r.mem_we;
	assign mem_re_out = s_r.mem_re;
	// The second push byte is written after the state is idle again, so it stalls too.
	assign core_stall_out = (s_r.stk != STK_IDLE) | s_r.mem_we | s_r.mem_re |
		(s_r.mode != MODE_ON);
	assign pc_load_out = s_r.pc_load;
	assign pc_value_out = s_r.pc_value;
	assign context_load_out = s_r.ctx_load;
	assign working_register_out = s_r.acc_out;
	assign flag_register_out = s_r.flg_out;
	assign chip_reset_out = s_r.wdt_rst;
	assign sys_clk_en_out = s_r.mode == MODE_ON;
	assign program_mem_on_out = s_r.mode == MODE_ON;
	assign fast_rc_osc_en_out = s_r.misc[MISC_FAST_OSC_EN] & (s_r.mode != MODE_DOWN);
	assign slow_rc_osc_en_out = s_r.misc[MISC_SLOW_OSC_EN] &
		(s_r.mode != MODE_DOWN);
	assign nano_rc_osc_en_out = s_r.aux2[AUX_NANO_EN];
	assign timer_run_out = run;
endmodule
`default_nettype wire

// file: verification/isw_asserts.sv
`default_nettype none
module isw_asserts
	import supervisor_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [11:0] paddr_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [7:0] mem_rdata_in,
	input wire logic [7:0] mem_addr_out,
	input wire logic mem_we_out,
	input wire logic mem_re_out,
	input wire logic core_stall_out,
	input wire logic pc_load_out,
	input wire logic [15:0] pc_value_out,
	input wire logic context_load_out,
	input wire logic [7:0] working_register_out,
	input wire logic [7:0] flag_register_out,
	input wire logic chip_reset_out,
	input wire logic power_save_in,
	input wire logic power_down_in,
	input wire logic sys_clk_en_out,
	input wire logic program_mem_on_out,
	input wire logic fast_rc_osc_en_out,
	input wire logic slow_rc_osc_en_out,
	input wire logic nano_rc_osc_en_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (srst_in);
	// A pop reads two adjacent bytes, then waits one cycle for the high byte.
	sequence s_pop_tail;
		mem_re_out && mem_addr_out == $past(mem_addr_out) + 8'h01 ##1 !mem_re_out
			##1 (pc_load_out || context_load_out);
	endsequence
	a_pop_two_reads: assert property ($rose(mem_re_out) |=> s_pop_tail)
		else $error("stack pop order broken");
	a_pop_pc_value: assert property (
		pc_load_out && $past(mem_re_out, 3) |->
		pc_value_out == {$past(mem_rdata_in, 1), $past(mem_rdata_in, 2)})
		else $error("popped program counter wrong");
	a_ctx_restore_data: assert property (context_load_out |->
		working_register_out == $past(mem_rdata_in, 2) && flag_register_out == $past(mem_rdata_in, 1))
		else $error("restored context wrong");
	a_take_push_vector: assert property (
		pc_load_out && pc_value_out == INT_VECTOR |->
		mem_we_out && $past(mem_we_out) && mem_addr_out == $past(mem_addr_out) + 8'h01)
		else $error("vector load without two-byte push");
	a_stack_stalls: assert property (mem_we_out || mem_re_out |-> core_stall_out)
		else $error("stack access without stall");
	a_wdt_reset_pulse: assert property (chip_reset_out |=> !chip_reset_out && !core_stall_out)
		else $error("watchdog reset pulse wrong");
	a_save_clock_gate: assert property (
		power_save_in && !power_down_in && !core_stall_out |=>
		!sys_clk_en_out && !program_mem_on_out && $stable(fast_rc_osc_en_out)
		&& $stable(slow_rc_osc_en_out) && $stable(nano_rc_osc_en_out))
		else $error("power save gating wrong");
	a_down_osc_stop: assert property (
		power_down_in && !core_stall_out |=> !fast_rc_osc_en_out && !slow_rc_osc_en_out
		&& !sys_clk_en_out && $stable(nano_rc_osc_en_out))
		else $error("power down oscillators wrong");
	a_unmapped_error: assert property (psel_in && penable_in |->
		pready_out && pslverr_out == (paddr_in > 12'h020 || paddr_in[1:0] != 2'h0))
		else $error("bus answer wrong");
endmodule
bind interrupt_sleep_watchdog isw_asserts chk_u (.*);
`default_nettype wire

// file: verification/testbench.sv
`default_nettype none
module testbench
	import supervisor_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WT[4] = '{8, 16, 32, 64};
	logic sys_clk_in = 1'h0, srst_in = 1'h1, ce_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0;
	logic pwrite_in = 1'h0, er, slow_run = 1'h0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0, rd;
	logic [3:0] pstrb_in = 4'hf;
	logic [1:0] sdiv = 2'h0;
	logic slow_rc_osc_in = 1'h0, comparator_unit_in = 1'h0, sixteen_bit_timer_bit_in = 1'h0;
	logic [5:0] pins_in = 6'h00;
	logic [1:0] eight_bit_timer_irq_in = 2'h0, eight_bit_timer_match_in = 2'h0;
	logic led_pwm_generator_irq_in = 1'h0, sixteen_bit_timer_match_in = 1'h0;
	logic instr_boundary_in = 1'h0;
	logic [15:0] pc_in = 16'hbe37;
	logic [7:0] working_register_in = 8'h5a, flag_register_in = 8'hc3, mem_rdata_in = 8'h00;
	logic wdt_clear_in = 1'h0, global_enable_in = 1'h0, global_disable_in = 1'h0;
	logic return_irq_in = 1'h0, context_save_in = 1'h0, context_restore_in = 1'h0;
	logic power_save_in = 1'h0, power_down_in = 1'h0;
	wire logic [31:0] prdata_out;
	wire logic pready_out, pslverr_out, mem_we_out, mem_re_out, core_stall_out, pc_load_out;
	wire logic [7:0] mem_addr_out, mem_wdata_out, working_register_out, flag_register_out;
	wire logic context_load_out, chip_reset_out, sys_clk_en_out, program_mem_on_out;
	wire logic fast_rc_osc_en_out, slow_rc_osc_en_out, nano_rc_osc_en_out;
	wire logic [15:0] pc_value_out;
	wire logic [3:0] timer_run_out;
	logic [7:0] mem [256];
	int n_errors = 0, tests_run = 0, cyc = 0, n, i;

	interrupt_sleep_watchdog #(.WDT_T0(8), .WDT_T1(16), .WDT_T2(32), .WDT_T3(64)) dut_u (.*);

	initial forever #20 sys_clk_in = ~sys_clk_in;

	// The slow oscillator only runs when asked, so the watchdog stays quiet elsewhere.
	always @(posedge sys_clk_in) begin
		if (slow_run)
			sdiv <= sdiv + 2'h1;
		if (slow_run && sdiv == 2'h3)
			slow_rc_osc_in <= ~slow_rc_osc_in;
		if (mem_we_out)
			mem[mem_addr_out] <= mem_wdata_out;
		mem_rdata_in <= mem[mem_addr_out];
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict;
		end
	end

	task give_verdict;
		$display("errors %0d comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [47:0] got, input logic [47:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		psel_in <= 1'h1;
		penable_in <= 1'h0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'h1;
		@(posedge sys_clk_in);
		while (pready_out !== 1'h1)
			@(posedge sys_clk_in);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
	endtask

	task drv(input int k, input logic v);
		case (k)
			0: wdt_clear_in <= v;
			1: global_enable_in <= v;
			2: global_disable_in <= v;
			3: return_irq_in <= v;
			4: context_save_in <= v;
			5: context_restore_in <= v;
			6: power_save_in <= v;
			7: power_down_in <= v;
			default: sixteen_bit_timer_match_in <= v;
		endcase
	endtask

	task pz(input int k);
		@(posedge sys_clk_in);
		drv(k, 1'h1);
		@(posedge sys_clk_in);
		drv(k, 1'h0);
	endtask

	function logic sig(input int k);
		case (k)
			0: return mem_we_out;
			1: return pc_load_out;
			2: return context_load_out;
			3: return chip_reset_out;
			default: return sys_clk_en_out;
		endcase
	endfunction

	task wfor(input int k, output int c);
		c = 0;
		do begin
			@(negedge sys_clk_in);
			c++;
		end while (sig(k) !== 1'h1 && c < 2000);
	endtask

	initial begin
		repeat (16) @(posedge sys_clk_in);
		srst_in <= 1'h0;
		apb(0, ADDR_MISC_CTRL, 32'h0);
		chk(rd, 32'h700);
		apb(0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h11);
		apb(0, 12'h040, 32'h0);
		chk({er, rd}, {1'h1, 32'h0});
		apb(1, ADDR_EDGE_SELECT, 32'h90);
		eight_bit_timer_irq_in <= 2'h3;
		repeat (4) @(posedge sys_clk_in);
		apb(0, ADDR_INT_FLAGS, 32'h0);
		chk(rd, 32'h04);
		eight_bit_timer_irq_in <= 2'h0;
		led_pwm_generator_irq_in <= 1'h1;
		repeat (4) @(posedge sys_clk_in);
		apb(0, ADDR_INT_FLAGS, 32'h0);
		chk(rd, 32'h2c);
		apb(1, ADDR_INT_FLAGS, 32'h33);
		apb(0, ADDR_INT_FLAGS, 32'h0);
		chk(rd, 32'h20);
		apb(1, ADDR_STACK_PTR, 32'h20);
		apb(1, ADDR_INT_ENABLE, 32'h20);
		instr_boundary_in <= 1'h1;
		repeat (6) @(posedge sys_clk_in);
		apb(0, ADDR_STACK_PTR, 32'h0);
		chk(rd, 32'h20);
		pz(1);
		wfor(0, n);
		chk({mem_addr_out, mem_wdata_out}, {8'h20, pc_in[7:0]});
		@(negedge sys_clk_in);
		chk({mem_addr_out, mem_wdata_out, pc_load_out, pc_value_out},
			{8'h21, pc_in[15:8], 1'h1, INT_VECTOR});
		apb(0, ADDR_STACK_PTR, 32'h0);
		chk(rd, 32'h22);
		apb(0, ADDR_STATUS, 32'h0);
		chk(rd[8], 1'h0);
		apb(1, ADDR_INT_FLAGS, 32'h1f);
		pz(3);
		wfor(1, n);
		chk(pc_value_out, pc_in);
		apb(0, ADDR_STACK_PTR, 32'h0);
		chk(rd, 32'h20);
		apb(0, ADDR_STATUS, 32'h0);
		chk(rd[8], 1'h1);
		pz(2);
		apb(0, ADDR_STATUS, 32'h0);
		chk(rd[8], 1'h0);
		pz(4);
		working_register_in <= 8'h00;
		flag_register_in <= 8'h00;
		repeat (3) @(posedge sys_clk_in);
		pz(5);
		wfor(2, n);
		chk({working_register_out, flag_register_out}, 16'h5ac3);
		for (i = 0; i < 4; i++) begin
			apb(1, ADDR_MISC_CTRL, 32'h700 | 32'(i));
			pz(0);
			slow_run <= 1'h1;
			wfor(3, n);
			slow_run <= 1'h0;
			chk(n > (WT[i] - 1) * 8 && n <= WT[i] * 8 + 16, 1'h1);
			apb(0, ADDR_MISC_CTRL, 32'h0);
			chk(rd, 32'h700);
		end
		// Watchdog off before sleeping, slow source kept on for the wake count.
		apb(1, ADDR_MISC_CTRL, 32'h600);
		apb(1, ADDR_PIN_CFG, 32'h202);
		apb(1, ADDR_TIMER_SRC, 32'h2);
		slow_run <= 1'h1;
		for (i = 0; i < 2; i++) begin
			apb(1, ADDR_MISC_CTRL, i ? 32'h620 : 32'h600);
			pz(6);
			@(negedge sys_clk_in);
			chk({sys_clk_en_out, program_mem_on_out, fast_rc_osc_en_out, slow_rc_osc_en_out},
				4'h3);
			chk($countones(timer_run_out), 1);
			@(posedge sys_clk_in);
			pins_in[2] <= ~pins_in[2];
			repeat (200) @(negedge sys_clk_in);
			chk(sys_clk_en_out, 1'h0);
			if (i)
				pz(8);
			else begin
				@(posedge sys_clk_in);
				pins_in[1] <= ~pins_in[1];
			end
			wfor(4, n);
			chk(n > (16 >> i) * 8 - 8 && n <= (16 >> i) * 8 + 24, 1'h1);
		end
		pz(7);
		@(negedge sys_clk_in);
		chk({fast_rc_osc_en_out, slow_rc_osc_en_out, nano_rc_osc_en_out, sys_clk_en_out},
			4'h0);
		pz(8);
		repeat (200) @(negedge sys_clk_in);
		chk(sys_clk_en_out, 1'h0);
		@(posedge sys_clk_in);
		pins_in[1] <= ~pins_in[1];
		wfor(4, n);
		chk(n <= 16 * 8 + 24, 1'h1);
		// Comparator toggle with both enables wakes from power-save.
		apb(1, ADDR_AUX_CTRL_TWO, 32'h7);
		pz(6);
		@(posedge sys_clk_in);
		comparator_unit_in <= 1'h1;
		wfor(4, n);
		chk(n > 6 * 8 && n <= 8 * 8 + 24, 1'h1);
		// Eight-bit timer on the nano oscillator still wakes from power-down.
		apb(1, ADDR_TIMER_SRC, 32'h30);
		pz(7);
		@(posedge sys_clk_in);
		eight_bit_timer_match_in <= 2'h2;
		@(posedge sys_clk_in);
		eight_bit_timer_match_in <= 2'h0;
		wfor(4, n);
		chk(n > 6 * 8 && n <= 8 * 8 + 24, 1'h1);
		give_verdict;
	end
endmodule
`default_nettype wire
